//--- src/caa_top.sv
// Register access for the counter high byte and the six capture/compare modules
`timescale 1ns/100ps
module caa_top #(
	parameter int NUM_CHAN = caa_pkg::NUM_CHAN
) (
	input wire logic clk,
	input wire logic reset_n,
	input wire caa_pkg::caa_byte_t sfrAddr,
	input wire caa_pkg::caa_byte_t sfrPage,
	input wire caa_pkg::caa_byte_t sfrWrData,
	input wire logic sfrWr,
	input wire logic sfrRd,
	input wire caa_pkg::caa_byte_t counterLow,
	input wire logic counterCarry,
	input wire logic watchdogEnable,
	input wire logic reloadSelect,
	input wire logic [NUM_CHAN-1:0] enLoad,
	input wire logic [NUM_CHAN-1:0] enValue,
	output caa_pkg::caa_byte_t sfrRdData,
	output logic sfrRdValid,
	output caa_pkg::caa_byte_t counterHigh,
	output logic [NUM_CHAN-1:0] compareEnable,
	output logic [NUM_CHAN-1:0] matchFlag
);
	// ----------------------------------------
	// Decode
	// ----------------------------------------
	logic counterLowHit;
	logic counterHighHit;
	logic [NUM_CHAN-1:0] lowHit;
	logic [NUM_CHAN-1:0] highHit;
	logic [NUM_CHAN-1:0] chanEnable;
	logic [NUM_CHAN-1:0] chanMatch;
	caa_pkg::caa_word_t chanCapture [NUM_CHAN];
	caa_pkg::caa_word_t chanReload [NUM_CHAN];
	caa_pkg::caa_byte_t snapshot;
	caa_pkg::caa_byte_t next_counterHigh;
	caa_pkg::caa_byte_t next_rdData;
	caa_pkg::caa_word_t liveCount;
	logic counterHighWrite;
	logic snapshotLoad;
	logic anyHit;

	caa_decode #(
		.NUM_CHAN(NUM_CHAN)
	) u_decode (
		.sfrAddr(sfrAddr),
		.sfrPage(sfrPage),
		.counterLowHit(counterLowHit),
		.counterHighHit(counterHighHit),
		.lowHit(lowHit),
		.highHit(highHit)
	);

	assign liveCount = {counterHigh, counterLow};
	assign counterHighWrite = sfrWr && counterHighHit && !watchdogEnable;
	// snapshot follows a read of the low byte
	assign snapshotLoad = sfrRd && counterLowHit;
	// write wins over a carry in the same cycle
	assign next_counterHigh = counterHighWrite ? sfrWrData
		: caa_pkg::caa_byte_t'(counterHigh + {7'h00, counterCarry});
	// Low-byte hit answers elsewhere, so it does not count here
	assign anyHit = counterHighHit || (|lowHit) || (|highHit);

	// ----------------------------------------
	// Channels
	// ----------------------------------------
	for (genvar i = 0; i < NUM_CHAN; i++)
	begin : g_chan
		caa_chan_if chIf ();

		assign chIf.wrLow = sfrWr && lowHit[i];
		assign chIf.wrHigh = sfrWr && highHit[i];
		assign chIf.wrData = sfrWrData;
		assign chIf.reloadSelect = reloadSelect;
		assign chIf.counter = liveCount;
		assign chIf.enLoad = enLoad[i];
		assign chIf.enValue = enValue[i];
		assign chanEnable[i] = chIf.compareEnable;
		assign chanMatch[i] = chIf.match;
		assign chanCapture[i] = chIf.captureValue;
		assign chanReload[i] = chIf.reloadValue;

		caa_chan u_chan (
			.clk(clk),
			.reset_n(reset_n),
			.bus(chIf.chan)
		);
	end

	assign compareEnable = chanEnable;
	assign matchFlag = chanMatch;

	// ----------------------------------------
	// Read data selection
	// ----------------------------------------
	always_comb
	begin
		caa_pkg::caa_word_t sel;
		sel = caa_pkg::RESET_WORD;
		next_rdData = caa_pkg::RESET_BYTE;
		// high byte reads come from the snapshot, not the live count
		if (counterHighHit)
			next_rdData = snapshot;
		for (int i = 0; i < NUM_CHAN; i++)
		begin
			// reload select picks the word behind the address
			sel = reloadSelect ? chanReload[i] : chanCapture[i];
			if (lowHit[i])
				next_rdData = sel[caa_pkg::BYTE_LO +: caa_pkg::BYTE_W];
			if (highHit[i])
				next_rdData = sel[caa_pkg::BYTE_HI +: caa_pkg::BYTE_W];
		end
	end

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	always_ff @(posedge clk)
	begin
		if (!reset_n)
		begin
			counterHigh <= caa_pkg::RESET_BYTE;
			snapshot <= caa_pkg::RESET_BYTE;
			sfrRdData <= caa_pkg::RESET_BYTE;
			sfrRdValid <= 1'b0;
		end
		else
		begin
			counterHigh <= next_counterHigh;
			if (snapshotLoad)
				snapshot <= counterHigh;
			// Unmapped reads return zero with valid low
			sfrRdData <= (sfrRd && anyHit) ? next_rdData : caa_pkg::RESET_BYTE;
			sfrRdValid <= sfrRd && anyHit;
		end
	end

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!reset_n);

	sequence s_low_read;
		sfrRd && counterLowHit;
	endsequence

	sequence s_high_read;
		sfrRd && counterHighHit;
	endsequence

	a_high_write: assert property (
		sfrWr && counterHighHit && !watchdogEnable |=> counterHigh == $past(sfrWrData))
		else $error("counter high byte write not stored");

	a_snap_read: assert property (
		s_low_read ##1 s_high_read |=> sfrRdValid && (sfrRdData == $past(counterHigh, 2)))
		else $error("counter high read is not the snapshot");

	a_snap_hold: assert property (
		!(sfrRd && counterLowHit) |=> $stable(snapshot))
		else $error("snapshot changed without a low byte read");

	a_watchdog_lock: assert property (
		sfrWr && counterHighHit && watchdogEnable
		|=> counterHigh == caa_pkg::caa_byte_t'($past(counterHigh) + {7'h00, $past(counterCarry)}))
		else $error("counter high byte changed under watchdog");

	// ----------------------------------------
	// Counter, snapshot, read-port and decode checks
	// ----------------------------------------
	a_carry_step: assert property (
		!counterHighWrite
		|=> counterHigh == caa_pkg::caa_byte_t'($past(counterHigh) + {7'h00, $past(counterCarry)}))
		else $error("counter high byte did not follow the carry");

	a_read_valid: assert property (
		!sfrRd
		|=> !sfrRdValid)
		else $error("read valid without a read");

	a_idle_data: assert property (
		!sfrRdValid
		|-> sfrRdData == caa_pkg::RESET_BYTE)
		else $error("read data not zero while idle");

	a_snap_load: assert property (
		s_low_read
		|=> snapshot == $past(counterHigh))
		else $error("snapshot not loaded on low byte read");

	a_snap_return: assert property (
		s_high_read
		|=> sfrRdValid && sfrRdData == $past(snapshot))
		else $error("counter high read did not return the snapshot");

	a_snap_no_follow: assert property (
		counterCarry && !(sfrRd && counterLowHit)
		|=> $stable(snapshot))
		else $error("snapshot followed the live counter");

	// Miss covers the low byte too: that read is answered outside this block
	a_miss_read: assert property (
		sfrRd && !anyHit
		|=> !sfrRdValid && sfrRdData == caa_pkg::RESET_BYTE)
		else $error("unmapped read answered");

	a_page_miss: assert property (
		sfrPage != caa_pkg::SFR_PAGE
		|-> !counterLowHit && !counterHighHit && !(|lowHit) && !(|highHit))
		else $error("decode hit on a foreign page");

	a_decode_onehot: assert property (
		sfrRd || sfrWr
		|-> $onehot0({lowHit, highHit, counterLowHit, counterHighHit}))
		else $error("more than one address decoded");

	// ----------------------------------------
	// Per-module checks
	// ----------------------------------------
	for (genvar i = 0; i < NUM_CHAN; i++)
	begin : g_chk
		// Bus write on this module overrides a mode-register load
		logic busTouch;
		assign busTouch = sfrWr && (lowHit[i] || highHit[i]);

		a_low_store: assert property (
			sfrWr && lowHit[i] && !reloadSelect
			|=> chanCapture[i][caa_pkg::BYTE_LO +: caa_pkg::BYTE_W] == $past(sfrWrData))
			else $error("capture low byte not stored");

		a_high_store: assert property (
			sfrWr && highHit[i] && !reloadSelect
			|=> chanCapture[i][caa_pkg::BYTE_HI +: caa_pkg::BYTE_W] == $past(sfrWrData))
			else $error("capture high byte not stored");

		a_reload_low: assert property (
			sfrWr && lowHit[i] && reloadSelect
			|=> $stable(chanCapture[i]) && chanReload[i][caa_pkg::BYTE_LO +: caa_pkg::BYTE_W] == $past(sfrWrData))
			else $error("reload low byte alias wrong");

		a_reload_high: assert property (
			sfrRd && highHit[i] && reloadSelect
			|=> sfrRdData == $past(chanReload[i][caa_pkg::BYTE_HI +: caa_pkg::BYTE_W]))
			else $error("reload high byte read wrong");

		a_low_clears: assert property (
			sfrWr && lowHit[i] |=> !compareEnable[i])
			else $error("low byte write did not clear enable");

		a_high_sets: assert property (
			sfrWr && highHit[i] |=> compareEnable[i])
			else $error("high byte write did not set enable");

		a_compare_match: assert property (
			compareEnable[i] && (liveCount == chanCapture[i]) |=> matchFlag[i])
			else $error("enabled compare missed a match");

		a_compare_off: assert property (
			!compareEnable[i] |=> !matchFlag[i])
			else $error("match flagged while compare disabled");

		a_select_capture: assert property (
			sfrRd && lowHit[i] && !reloadSelect
			|=> sfrRdValid && sfrRdData == $past(chanCapture[i][caa_pkg::BYTE_LO +: caa_pkg::BYTE_W]))
			else $error("capture low byte read wrong");

		a_high_read: assert property (
			sfrRd && highHit[i] && !reloadSelect
			|=> sfrRdValid && sfrRdData == $past(chanCapture[i][caa_pkg::BYTE_HI +: caa_pkg::BYTE_W]))
			else $error("capture high byte read wrong");

		a_reload_low_rd: assert property (
			sfrRd && lowHit[i] && reloadSelect
			|=> sfrRdValid && sfrRdData == $past(chanReload[i][caa_pkg::BYTE_LO +: caa_pkg::BYTE_W]))
			else $error("reload low byte read wrong");

		a_reload_high_wr: assert property (
			sfrWr && highHit[i] && reloadSelect
			|=> $stable(chanCapture[i]) && chanReload[i][caa_pkg::BYTE_HI +: caa_pkg::BYTE_W] == $past(sfrWrData))
			else $error("reload high byte alias write wrong");

		a_low_keeps_reload: assert property (
			sfrWr && lowHit[i] && !reloadSelect
			|=> $stable(chanReload[i]))
			else $error("capture low write touched the reload word");

		a_high_keeps_reload: assert property (
			sfrWr && highHit[i] && !reloadSelect
			|=> $stable(chanReload[i]))
			else $error("capture high write touched the reload word");

		// Mode load only sticks when the bus leaves the module alone
		a_mode_load: assert property (
			enLoad[i] && !busTouch
			|=> compareEnable[i] == $past(enValue[i]))
			else $error("mode load did not reach the enable");

		a_enable_hold: assert property (
			!enLoad[i] && !busTouch
			|=> $stable(compareEnable[i]))
			else $error("comparator enable moved on its own");

		// Match must drop as soon as the count differs
		a_compare_miss: assert property (
			liveCount != chanCapture[i]
			|=> !matchFlag[i])
			else $error("match flagged without equal count");
	end
endmodule : caa_top

//--- common/caa_pkg.sv
// Constants, types and decode helpers for the counter array register access block
package caa_pkg;
	typedef logic [7:0] caa_byte_t;
	typedef logic [15:0] caa_word_t;

	localparam int NUM_CHAN = 6;
	localparam caa_byte_t SFR_PAGE = 8'h00;
	localparam caa_byte_t ADDR_COUNTER_LOW = 8'hF9;
	localparam caa_byte_t ADDR_COUNTER_HIGH = 8'hFA;
	localparam caa_byte_t LOW_ADDR [0:NUM_CHAN-1] = '{8'hFB, 8'hE9, 8'hEB, 8'hED, 8'hFD, 8'hD2};
	localparam caa_byte_t HIGH_ADDR [0:NUM_CHAN-1] = '{8'hFC, 8'hEA, 8'hEC, 8'hEE, 8'hFE, 8'hD3};
	localparam caa_byte_t RESET_BYTE = 8'h00;
	localparam caa_word_t RESET_WORD = 16'h0000;
	localparam int BYTE_LO = 0;
	localparam int BYTE_HI = 8;
	localparam int BYTE_W = 8;

	// Page and address both have to match; a single wrong page bit must miss
	function automatic logic addr_hit(input caa_byte_t addr, input caa_byte_t page, input caa_byte_t target);
		addr_hit = (page == SFR_PAGE) && (addr == target);
	endfunction : addr_hit
endpackage : caa_pkg

//--- common/caa_chan_if.sv
// Carrier between the register front end and one capture/compare channel
`timescale 1ns/100ps
interface caa_chan_if;
	logic wrLow;
	logic wrHigh;
	caa_pkg::caa_byte_t wrData;
	logic reloadSelect;
	caa_pkg::caa_word_t counter;
	logic enLoad;
	logic enValue;
	caa_pkg::caa_word_t captureValue;
	caa_pkg::caa_word_t reloadValue;
	logic compareEnable;
	logic match;

	modport ctrl (
		output wrLow, wrHigh, wrData, reloadSelect, counter, enLoad, enValue,
		input captureValue, reloadValue, compareEnable, match
	);
	modport chan (
		input wrLow, wrHigh, wrData, reloadSelect, counter, enLoad, enValue,
		output captureValue, reloadValue, compareEnable, match
	);
endinterface : caa_chan_if

//--- src/caa_decode.sv
// Special-function address decode for the counter and the capture/compare modules
`timescale 1ns/100ps
module caa_decode #(
	parameter int NUM_CHAN = caa_pkg::NUM_CHAN
) (
	input wire caa_pkg::caa_byte_t sfrAddr,
	input wire caa_pkg::caa_byte_t sfrPage,
	output logic counterLowHit,
	output logic counterHighHit,
	output logic [NUM_CHAN-1:0] lowHit,
	output logic [NUM_CHAN-1:0] highHit
);
	assign counterLowHit = caa_pkg::addr_hit(sfrAddr, sfrPage, caa_pkg::ADDR_COUNTER_LOW);
	assign counterHighHit = caa_pkg::addr_hit(sfrAddr, sfrPage, caa_pkg::ADDR_COUNTER_HIGH);

	// ----------------------------------------
	// Per-module byte decode
	// ----------------------------------------
	for (genvar i = 0; i < NUM_CHAN; i++)
	begin : g_dec
		assign lowHit[i] = caa_pkg::addr_hit(sfrAddr, sfrPage, caa_pkg::LOW_ADDR[i]);
		assign highHit[i] = caa_pkg::addr_hit(sfrAddr, sfrPage, caa_pkg::HIGH_ADDR[i]);
	end
endmodule : caa_decode

//--- src/caa_chan.sv
// One capture/compare channel: value, auto-reload alias, comparator enable, match
`timescale 1ns/100ps
module caa_chan (
	input wire logic clk,
	input wire logic reset_n,
	caa_chan_if.chan bus
);
	caa_pkg::caa_word_t capture;
	caa_pkg::caa_word_t reload;
	logic enable;
	logic match;
	logic next_enable;
	logic countEqual;

	assign bus.captureValue = capture;
	assign bus.reloadValue = reload;
	assign bus.compareEnable = enable;
	assign bus.match = match;

	// low byte write clears, high byte write sets
	assign next_enable = bus.wrLow ? 1'b0 : (bus.wrHigh ? 1'b1 : (bus.enLoad ? bus.enValue : enable));
	assign countEqual = enable && (bus.counter == capture);

	always_ff @(posedge clk)
	begin
		if (!reset_n)
		begin
			capture <= caa_pkg::RESET_WORD;
			reload <= caa_pkg::RESET_WORD;
			enable <= 1'b0;
			match <= 1'b0;
		end
		else
		begin
			// select steers the byte to capture or reload
			if (bus.wrLow && !bus.reloadSelect)
				capture[caa_pkg::BYTE_LO +: caa_pkg::BYTE_W] <= bus.wrData;
			if (bus.wrLow && bus.reloadSelect)
				reload[caa_pkg::BYTE_LO +: caa_pkg::BYTE_W] <= bus.wrData;
			if (bus.wrHigh && !bus.reloadSelect)
				capture[caa_pkg::BYTE_HI +: caa_pkg::BYTE_W] <= bus.wrData;
			if (bus.wrHigh && bus.reloadSelect)
				reload[caa_pkg::BYTE_HI +: caa_pkg::BYTE_W] <= bus.wrData;
			enable <= next_enable;
			match <= countEqual;
		end
	end
endmodule : caa_chan

//--- bench/testbench.sv
// Self-checking testbench for the counter array register access block
`timescale 1ns/100ps
module testbench;
	logic clk;
	logic reset_n;
	logic sfrWr;
	logic sfrRd;
	logic counterCarry;
	logic watchdogEnable;
	logic reloadSelect;
	logic sfrRdValid;
	caa_pkg::caa_byte_t sfrAddr;
	caa_pkg::caa_byte_t sfrPage;
	caa_pkg::caa_byte_t sfrWrData;
	caa_pkg::caa_byte_t counterLow;
	caa_pkg::caa_byte_t sfrRdData;
	caa_pkg::caa_byte_t counterHigh;
	caa_pkg::caa_byte_t rd;
	logic [5:0] enLoad;
	logic [5:0] enValue;
	logic [5:0] compareEnable;
	logic [5:0] matchFlag;
	int mismatches;
	int checks_done;

	caa_top i_dut (
		.clk(clk),
		.reset_n(reset_n),
		.sfrAddr(sfrAddr),
		.sfrPage(sfrPage),
		.sfrWrData(sfrWrData),
		.sfrWr(sfrWr),
		.sfrRd(sfrRd),
		.counterLow(counterLow),
		.counterCarry(counterCarry),
		.watchdogEnable(watchdogEnable),
		.reloadSelect(reloadSelect),
		.enLoad(enLoad),
		.enValue(enValue),
		.sfrRdData(sfrRdData),
		.sfrRdValid(sfrRdValid),
		.counterHigh(counterHigh),
		.compareEnable(compareEnable),
		.matchFlag(matchFlag)
	);

	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		checks_done++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	// Inputs change on the falling edge only
	task automatic wr(input caa_pkg::caa_byte_t a, input caa_pkg::caa_byte_t d);
		@(negedge clk);
		sfrAddr = a;
		sfrWrData = d;
		sfrWr = 1'b1;
		@(negedge clk);
		sfrWr = 1'b0;
	endtask : wr

	// Answer stands one cycle, so it is sampled at the release edge
	task automatic rdb(input caa_pkg::caa_byte_t a);
		@(negedge clk);
		sfrAddr = a;
		sfrRd = 1'b1;
		@(negedge clk);
		sfrRd = 1'b0;
		rd = sfrRdData;
	endtask : rdb

	task automatic rdchk(input caa_pkg::caa_byte_t a, input caa_pkg::caa_byte_t exp);
		rdb(a);
		check(rd, exp);
		check({7'h00, sfrRdValid}, 8'h01);
	endtask : rdchk

	task automatic end_sim();
		$display("checks %0d mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : end_sim

	// Tests take well under 1000 cycles
	initial
	begin
		#200000;
		mismatches++;
		end_sim();
	end

	initial
	begin
		mismatches = 0;
		checks_done = 0;
		{reset_n, sfrWr, sfrRd, counterCarry, watchdogEnable, reloadSelect} = '0;
		{sfrAddr, sfrPage, sfrWrData} = '0;
		counterLow = 8'h76;
		enLoad = '0;
		enValue = '0;
		repeat (21) @(negedge clk);
		reset_n = 1'b1;
		// ----------------------------------------
		// Reset values
		// ----------------------------------------
		for (int i = 0; i < 6; i++)
		begin
			rdchk(caa_pkg::LOW_ADDR[i], 8'h00);
			rdchk(caa_pkg::HIGH_ADDR[i], 8'h00);
		end
		rdchk(caa_pkg::ADDR_COUNTER_HIGH, 8'h00);
		check({2'b00, compareEnable}, 8'h00);
		$display("test reset values done");
		// ----------------------------------------
		// Byte writes and enable side effects
		// ----------------------------------------
		for (int i = 0; i < 6; i++)
		begin
			wr(caa_pkg::HIGH_ADDR[i], 8'hA0 + 8'(i));
			check({7'h00, compareEnable[i]}, 8'h01);
			wr(caa_pkg::LOW_ADDR[i], 8'h50 + 8'(i));
			check({7'h00, compareEnable[i]}, 8'h00);
			rdchk(caa_pkg::HIGH_ADDR[i], 8'hA0 + 8'(i));
			rdchk(caa_pkg::LOW_ADDR[i], 8'h50 + 8'(i));
		end
		$display("test module bytes done");
		// ----------------------------------------
		// Auto-reload alias
		// ----------------------------------------
		reloadSelect = 1'b1;
		for (int i = 0; i < 6; i++)
		begin
			wr(caa_pkg::LOW_ADDR[i], 8'h3C ^ 8'(i));
			check({7'h00, compareEnable[i]}, 8'h00);
			wr(caa_pkg::HIGH_ADDR[i], 8'hC3 ^ 8'(i));
			check({7'h00, compareEnable[i]}, 8'h01);
			rdchk(caa_pkg::LOW_ADDR[i], 8'h3C ^ 8'(i));
			rdchk(caa_pkg::HIGH_ADDR[i], 8'hC3 ^ 8'(i));
		end
		reloadSelect = 1'b0;
		for (int i = 0; i < 6; i++)
		begin
			rdchk(caa_pkg::LOW_ADDR[i], 8'h50 + 8'(i));
			rdchk(caa_pkg::HIGH_ADDR[i], 8'hA0 + 8'(i));
		end
		$display("test reload alias done");
		// ----------------------------------------
		// Counter high byte, watchdog lock, snapshot
		// ----------------------------------------
		wr(caa_pkg::ADDR_COUNTER_HIGH, 8'h12);
		check(counterHigh, 8'h12);
		watchdogEnable = 1'b1;
		wr(caa_pkg::ADDR_COUNTER_HIGH, 8'h34);
		check(counterHigh, 8'h12);
		watchdogEnable = 1'b0;
		rdb(caa_pkg::ADDR_COUNTER_LOW);
		counterCarry = 1'b1;
		@(negedge clk);
		counterCarry = 1'b0;
		check(counterHigh, 8'h13);
		rdchk(caa_pkg::ADDR_COUNTER_HIGH, 8'h12);
		rdb(caa_pkg::ADDR_COUNTER_LOW);
		rdchk(caa_pkg::ADDR_COUNTER_HIGH, 8'h13);
		$display("test counter high byte done");
		// ----------------------------------------
		// Compare against the running counter
		// ----------------------------------------
		wr(caa_pkg::LOW_ADDR[0], 8'h77);
		wr(caa_pkg::HIGH_ADDR[0], 8'h13);
		@(negedge clk);
		check({7'h00, matchFlag[0]}, 8'h00);
		counterLow = 8'h77;
		@(negedge clk);
		check({7'h00, matchFlag[0]}, 8'h01);
		wr(caa_pkg::LOW_ADDR[0], 8'h77);
		@(negedge clk);
		check({7'h00, matchFlag[0]}, 8'h00);
		enLoad[0] = 1'b1;
		enValue[0] = 1'b1;
		@(negedge clk);
		enLoad[0] = 1'b0;
		@(negedge clk);
		check({7'h00, compareEnable[0]}, 8'h01);
		check({7'h00, matchFlag[0]}, 8'h01);
		$display("test compare done");
		// ----------------------------------------
		// Unmapped address and wrong page
		// ----------------------------------------
		rdb(8'hF8);
		check({7'h00, sfrRdValid}, 8'h00);
		check(rd, 8'h00);
		sfrPage = 8'h01;
		rdb(caa_pkg::ADDR_COUNTER_HIGH);
		check({7'h00, sfrRdValid}, 8'h00);
		wr(caa_pkg::HIGH_ADDR[0], 8'hFF);
		sfrPage = 8'h00;
		rdchk(caa_pkg::HIGH_ADDR[0], 8'h13);
		$display("test decode misses done");
		// ----------------------------------------
		// Low byte read straight into high byte read
		// ----------------------------------------
		counterCarry = 1'b1;
		@(negedge clk);
		counterCarry = 1'b0;
		sfrAddr = caa_pkg::ADDR_COUNTER_LOW;
		sfrRd = 1'b1;
		@(negedge clk);
		sfrAddr = caa_pkg::ADDR_COUNTER_HIGH;
		@(negedge clk);
		sfrRd = 1'b0;
		check(sfrRdData, 8'h14);
		check({7'h00, sfrRdValid}, 8'h01);
		$display("test coherent read done");
		end_sim();
	end
endmodule : testbench
